//--- dual_timebase_ccu.sv
// dual time base capture/compare unit with apb register access
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module dual_timebase_ccu (
	input  wire logic                                  clk,
	input  wire logic                                  rst,
	input  wire logic                                  psel,
	input  wire logic                                  penable,
	input  wire logic                                  pwrite,
	input  wire logic [dual_timebase_ccu_pkg::AW-1:0]  paddr,
	input  wire logic [31:0]                           pwdata,
	output var  logic [31:0]                           prdata,
	output var  logic                                  pready,
	output var  logic                                  pslverr,
	input  wire logic [dual_timebase_ccu_pkg::NUM_CH-1:0] ch_in,
	output var  logic [dual_timebase_ccu_pkg::NUM_CH-1:0] ch_out,
	output var  logic [dual_timebase_ccu_pkg::NUM_CH-1:0] ch_oe,
	input  wire logic                                  gp_timer_six_ovf,
	input  wire logic                                  ext_count_in,
	output var  logic                                  irq
);
	localparam int N = dual_timebase_ccu_pkg::NUM_CH;
	localparam int H = dual_timebase_ccu_pkg::HALF_CH;
	localparam int W = dual_timebase_ccu_pkg::TB_W;

	dual_timebase_ccu_pkg::ch_cfg_s               cfg_reg [N];
	logic [W-1:0]                                 val_reg [N];
	dual_timebase_ccu_pkg::tb_cfg_s               tb_cfg_reg [2];
	logic                                         stagger_reg;
	logic [W-1:0]                                 cnt_reg [2];
	logic [W-1:0]                                 rld_reg [2];
	logic [1:0]                                   step_reg;
	logic [1:0]                                   ovf_reg;
	logic [dual_timebase_ccu_pkg::PSC_W-1:0]      psc_reg;
	logic [dual_timebase_ccu_pkg::INT_W-1:0]      status_reg;
	logic [dual_timebase_ccu_pkg::INT_W-1:0]      mask_reg;
	logic [N-1:0]                                 done_reg;
	logic [N-1:0]                                 in_s1_reg;
	logic [N-1:0]                                 in_s2_reg;
	logic [N-1:0]                                 in_s3_reg;
	logic [2:0]                                   ext_sync_reg;
	logic [31:0]                                  rdata_next;
	logic                                         err_next;
	logic                                         wr_en;
	logic [1:0]                                   tick;
	logic [1:0]                                   wr_cnt;
	logic [N-1:0]                                 cap_evt;
	logic [N-1:0]                                 act;
	logic [N-1:0]                                 once;

	function automatic logic hit_block(input logic [11:0] a, input logic [11:0] base);
		hit_block = (a[11:6] == base[11:6]);
	endfunction

	function automatic logic psc_tick(input logic [7:0] c, input logic [2:0] n);
		logic [7:0] m;
		m = 8'((9'h001 << n) - 9'h001);
		psc_tick = ((c & m) == m);
	endfunction

	function automatic logic is_cmp(input dual_timebase_ccu_pkg::ch_mode_e m);
		is_cmp = m[2];
	endfunction

	assign wr_en = psel & penable & pready & pwrite & ~pslverr;

	// pin and external count synchronisers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			in_s1_reg    <= '0;
			in_s2_reg    <= '0;
			in_s3_reg    <= '0;
			ext_sync_reg <= '0;
		end else begin
			in_s1_reg    <= ch_in;
			in_s2_reg    <= in_s1_reg;
			in_s3_reg    <= in_s2_reg;
			ext_sync_reg <= {ext_sync_reg[1:0], ext_count_in};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			psc_reg <= '0;
		end else begin
			psc_reg <= psc_reg + 8'h01;
		end
	end

	// tick source selection per time base
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			wr_cnt[k] = wr_en && (paddr == ((k == 0) ? dual_timebase_ccu_pkg::ADDR_CNT_A
				: dual_timebase_ccu_pkg::ADDR_CNT_B));
			case (tb_cfg_reg[k].src)
				dual_timebase_ccu_pkg::SRC_PSC: tick[k] = psc_tick(psc_reg, tb_cfg_reg[k].psc);
				dual_timebase_ccu_pkg::SRC_GP6: tick[k] = gp_timer_six_ovf;
				dual_timebase_ccu_pkg::SRC_EXT: tick[k] = ext_sync_reg[1] & ~ext_sync_reg[2];
				default: tick[k] = 1'b0;
			endcase
			if (stagger_reg && (psc_reg[2:0] != dual_timebase_ccu_pkg::STAGGER_MASK)) begin
				tick[k] = 1'b0;
			end
			tick[k] = tick[k] & tb_cfg_reg[k].run & ~wr_cnt[k];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg[0] <= dual_timebase_ccu_pkg::TB_RST;
			cnt_reg[1] <= dual_timebase_ccu_pkg::TB_RST;
			step_reg <= '0;
			ovf_reg  <= '0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				step_reg[k] <= tick[k];
				ovf_reg[k]  <= 1'b0;
				if (wr_cnt[k]) begin
					cnt_reg[k] <= pwdata[W-1:0];
				end else if (tick[k]) begin
					if (cnt_reg[k] == dual_timebase_ccu_pkg::TB_MAX) begin
						cnt_reg[k] <= rld_reg[k];
						ovf_reg[k] <= 1'b1;
					end else begin
						cnt_reg[k] <= W'(cnt_reg[k] + 16'h0001);
					end
				end
			end
		end
	end

	// channel events
	always_comb begin
		for (int i = 0; i < N; i++) begin
			once[i] = (cfg_reg[i].mode == dual_timebase_ccu_pkg::CMP_IRQ_ONCE) ||
				(cfg_reg[i].mode == dual_timebase_ccu_pkg::CMP_SET_ONCE);
			case (cfg_reg[i].mode)
				dual_timebase_ccu_pkg::CAP_RISE: cap_evt[i] = in_s2_reg[i] & ~in_s3_reg[i];
				dual_timebase_ccu_pkg::CAP_FALL: cap_evt[i] = ~in_s2_reg[i] & in_s3_reg[i];
				dual_timebase_ccu_pkg::CAP_BOTH: cap_evt[i] = in_s2_reg[i] ^ in_s3_reg[i];
				default: cap_evt[i] = 1'b0;
			endcase
			act[i] = is_cmp(cfg_reg[i].mode) && step_reg[cfg_reg[i].tb_sel] &&
				(cnt_reg[cfg_reg[i].tb_sel] == val_reg[i]);
			if (cfg_reg[i].single && !cfg_reg[i].arm) begin
				act[i] = 1'b0;
			end
			if (once[i] && done_reg[i] && !ovf_reg[cfg_reg[i].tb_sel]) begin
				act[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < N; i++) begin
				val_reg[i] <= dual_timebase_ccu_pkg::TB_RST;
			end
		end else begin
			for (int i = 0; i < N; i++) begin
				if (cap_evt[i]) begin
					val_reg[i] <= cnt_reg[cfg_reg[i].tb_sel];
				end else if (wr_en && hit_block(paddr, dual_timebase_ccu_pkg::ADDR_CH_VAL) &&
					(paddr[5:2] == 4'(i))) begin
					val_reg[i] <= pwdata[W-1:0];
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < N; i++) begin
				cfg_reg[i] <= '0;
			end
		end else begin
			for (int i = 0; i < N; i++) begin
				if (wr_en && hit_block(paddr, dual_timebase_ccu_pkg::ADDR_CH_CFG) &&
					(paddr[5:2] == 4'(i))) begin
					cfg_reg[i] <= dual_timebase_ccu_pkg::ch_cfg_s'(
						pwdata[dual_timebase_ccu_pkg::CH_CFG_W-1:0]);
				end else if (act[i] && cfg_reg[i].single) begin
					cfg_reg[i].arm <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done_reg <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				// overflow ends the period, a match wins
				if (act[i]) begin
					done_reg[i] <= 1'b1;
				end else if (ovf_reg[cfg_reg[i].tb_sel]) begin
					done_reg[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ch_out <= '0;
			ch_oe  <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				ch_oe[i] <= (cfg_reg[i].mode == dual_timebase_ccu_pkg::CMP_TOGGLE) ||
					(cfg_reg[i].mode == dual_timebase_ccu_pkg::CMP_SET_ONCE) ||
					((i < H) && cfg_reg[i % H].dbl);
				if (i >= H && cfg_reg[i % H].dbl) begin
					ch_oe[i] <= 1'b0;
				end else if ((i < H) && cfg_reg[i % H].dbl) begin
					// a match on either register toggles the shared pin, matches on both in one cycle do not
					if (act[i] ^ act[(i % H) + H]) begin
						ch_out[i] <= ~ch_out[i];
					end
				end else if (cfg_reg[i].mode == dual_timebase_ccu_pkg::CMP_TOGGLE) begin
					if (act[i]) begin
						ch_out[i] <= ~ch_out[i];
					end
				end else if (cfg_reg[i].mode == dual_timebase_ccu_pkg::CMP_SET_ONCE) begin
					// set on match, clear on overflow
					if (act[i]) begin
						ch_out[i] <= 1'b1;
					end else if (ovf_reg[cfg_reg[i].tb_sel]) begin
						ch_out[i] <= 1'b0;
					end
				end
			end
		end
	end

	// time base control and reload registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tb_cfg_reg[0] <= '0;
			tb_cfg_reg[1] <= '0;
			stagger_reg   <= 1'b0;
			rld_reg[0]    <= dual_timebase_ccu_pkg::TB_RST;
			rld_reg[1]    <= dual_timebase_ccu_pkg::TB_RST;
		end else if (wr_en) begin
			case (paddr)
				dual_timebase_ccu_pkg::ADDR_TB_CTRL: begin
					tb_cfg_reg[0] <= dual_timebase_ccu_pkg::tb_cfg_s'(
						pwdata[dual_timebase_ccu_pkg::TB_CFG_W-1:0]);
					tb_cfg_reg[1] <= dual_timebase_ccu_pkg::tb_cfg_s'(
						pwdata[2*dual_timebase_ccu_pkg::TB_CFG_W-1:dual_timebase_ccu_pkg::TB_CFG_W]);
					stagger_reg   <= pwdata[dual_timebase_ccu_pkg::STAGGER_BIT];
				end
				dual_timebase_ccu_pkg::ADDR_RLD_A: rld_reg[0] <= pwdata[W-1:0];
				dual_timebase_ccu_pkg::ADDR_RLD_B: rld_reg[1] <= pwdata[W-1:0];
				default: ;
			endcase
		end
	end

	// sticky interrupt status, set wins over clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_reg <= '0;
		end else begin
			// every compare action requests an interrupt
			status_reg <= (status_reg & ~((wr_en && paddr == dual_timebase_ccu_pkg::ADDR_INT_STATUS)
				? pwdata[dual_timebase_ccu_pkg::INT_W-1:0] : '0)) |
				{ovf_reg, (cap_evt | act)};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mask_reg <= '0;
			irq      <= 1'b0;
		end else begin
			if (wr_en && paddr == dual_timebase_ccu_pkg::ADDR_INT_MASK) begin
				mask_reg <= pwdata[dual_timebase_ccu_pkg::INT_W-1:0];
			end
			irq <= |(status_reg & mask_reg);
		end
	end

	// read decode
	always_comb begin
		rdata_next = dual_timebase_ccu_pkg::RD_ZERO;
		err_next   = 1'b0;
		if (hit_block(paddr, dual_timebase_ccu_pkg::ADDR_CH_CFG)) begin
			rdata_next[dual_timebase_ccu_pkg::CH_CFG_W-1:0] = cfg_reg[paddr[5:2]];
		end else if (hit_block(paddr, dual_timebase_ccu_pkg::ADDR_CH_VAL)) begin
			rdata_next[W-1:0] = val_reg[paddr[5:2]];
		end else begin
			case (paddr)
				dual_timebase_ccu_pkg::ADDR_TB_CTRL: begin
					rdata_next[2*dual_timebase_ccu_pkg::TB_CFG_W-1:0] = {tb_cfg_reg[1], tb_cfg_reg[0]};
					rdata_next[dual_timebase_ccu_pkg::STAGGER_BIT] = stagger_reg;
				end
				dual_timebase_ccu_pkg::ADDR_CNT_A: rdata_next[W-1:0] = cnt_reg[0];
				dual_timebase_ccu_pkg::ADDR_RLD_A: rdata_next[W-1:0] = rld_reg[0];
				dual_timebase_ccu_pkg::ADDR_CNT_B: rdata_next[W-1:0] = cnt_reg[1];
				dual_timebase_ccu_pkg::ADDR_RLD_B: rdata_next[W-1:0] = rld_reg[1];
				dual_timebase_ccu_pkg::ADDR_INT_STATUS: begin
					rdata_next[dual_timebase_ccu_pkg::INT_W-1:0] = status_reg;
				end
				dual_timebase_ccu_pkg::ADDR_INT_MASK: begin
					rdata_next[dual_timebase_ccu_pkg::INT_W-1:0] = mask_reg;
				end
				default: err_next = 1'b1;
			endcase
		end
		if (paddr[1:0] != 2'h0) begin
			err_next = 1'b1;
		end
	end

	// apb answer, one wait-free access phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata  <= dual_timebase_ccu_pkg::RD_ZERO;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & err_next;
			if (psel & ~penable & ~pwrite) begin
				prdata <= err_next ? dual_timebase_ccu_pkg::RD_ZERO : rdata_next;
			end
		end
	end
endmodule
`default_nettype wire

//--- dual_timebase_ccu_pkg.sv
// constants, types and register map of the dual time base capture/compare unit
package dual_timebase_ccu_pkg;
	localparam int          NUM_CH   = 16;
	localparam int          HALF_CH  = 8;
	localparam int          TB_W     = 16;
	localparam int          NUM_TB   = 2;
	localparam int          AW       = 12;
	localparam int          INT_W    = 18;
	localparam int          PSC_W    = 8;

	localparam logic [11:0] ADDR_TB_CTRL    = 12'h000;
	localparam logic [11:0] ADDR_CNT_A      = 12'h004;
	localparam logic [11:0] ADDR_RLD_A      = 12'h008;
	localparam logic [11:0] ADDR_CNT_B      = 12'h00c;
	localparam logic [11:0] ADDR_RLD_B      = 12'h010;
	localparam logic [11:0] ADDR_INT_STATUS = 12'h014;
	localparam logic [11:0] ADDR_INT_MASK   = 12'h018;
	localparam logic [11:0] ADDR_CH_CFG     = 12'h040;
	localparam logic [11:0] ADDR_CH_VAL     = 12'h080;

	localparam int          TB_CFG_W     = 6;
	localparam int          STAGGER_BIT  = 12;
	localparam int          INT_OVF_A    = 16;
	localparam int          INT_OVF_B    = 17;
	localparam logic [2:0]  STAGGER_MASK = 3'h7;
	localparam logic [15:0] TB_MAX       = 16'hffff;
	localparam logic [15:0] TB_RST       = 16'h0000;
	localparam logic [31:0] RD_ZERO      = 32'h0000_0000;

	typedef enum logic [2:0] {
		MODE_OFF      = 3'h0,
		CAP_RISE      = 3'h1,
		CAP_FALL      = 3'h2,
		CAP_BOTH      = 3'h3,
		CMP_IRQ       = 3'h4,
		CMP_TOGGLE    = 3'h5,
		CMP_IRQ_ONCE  = 3'h6,
		CMP_SET_ONCE  = 3'h7
	} ch_mode_e;

	typedef enum logic [1:0] {
		SRC_PSC  = 2'h0,
		SRC_GP6  = 2'h1,
		SRC_EXT  = 2'h2,
		SRC_HOLD = 2'h3
	} clk_src_e;

	typedef struct packed {
		logic     dbl;
		logic     arm;
		logic     single;
		logic     tb_sel;
		ch_mode_e mode;
	} ch_cfg_s;

	typedef struct packed {
		logic     run;
		clk_src_e src;
		logic [2:0] psc;
	} tb_cfg_s;

	localparam int          CH_CFG_W = 7;
endpackage

//--- channel_pin_model.sv
// model of the external signals on the channel pins
`timescale 1ns/100ps
`default_nettype none
module channel_pin_model (
	input  wire logic [15:0] drv,
	input  wire logic [15:0] ch_out,
	input  wire logic [15:0] ch_oe,
	output var  logic [15:0] ch_in
);
	always_comb ch_in = (ch_oe & ch_out) | (~ch_oe & drv);
endmodule
`default_nettype wire

//--- dual_timebase_ccu_props.sv
// bus, pin enable and interrupt properties of the capture/compare unit
`timescale 1ns/100ps
`default_nettype none
module dual_timebase_ccu_props (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [15:0] ch_oe,
	input wire logic        irq
);
	logic wr_q;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q <= 1'b0;
		end else begin
			wr_q <= psel && penable && pready && pwrite;
		end
	end

	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("no answer in the cycle after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	ready_cause_a: assert property (pready |-> $past(psel && !penable))
		else $error("ready without a setup cycle");
	err_with_ready_a: assert property (pslverr |-> pready && psel && penable)
		else $error("error flag outside an access cycle");
	err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
		else $error("refused read returned data");
	rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved without a read");
	irq_clear_a: assert property ($fell(irq) |-> $past(wr_q))
		else $error("interrupt dropped without a write");
	oe_from_cfg_a: assert property ($changed(ch_oe) |-> wr_q || $past(wr_q))
		else $error("pin enable changed without a write");
endmodule

bind dual_timebase_ccu dual_timebase_ccu_props u_props (
	.clk    (clk),
	.rst    (rst),
	.psel   (psel),
	.penable(penable),
	.pwrite (pwrite),
	.prdata (prdata),
	.pready (pready),
	.pslverr(pslverr),
	.ch_oe  (ch_oe),
	.irq    (irq)
);
`default_nettype wire

//--- test_dual_timebase_ccu.sv
// self-checking bench for the dual time base capture/compare unit
`timescale 1ns/100ps
`default_nettype none
module test_dual_timebase_ccu;
	logic        clk;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] drv = 16'h0000;
	logic [15:0] ch_in;
	logic [15:0] ch_out;
	logic [15:0] ch_oe;
	logic        gp6 = 1'b0;
	logic        ext = 1'b0;
	logic        irq;
	logic [31:0] rd;
	logic        err;
	logic [31:0] cap = 32'h0000_0000;
	int          fails = 0;
	int          n_tests = 0;
	int          ch_t[6] = '{2, 3, 4, 5, 7, 15};
	logic [6:0]  cf_t[6] = '{7'h04, 7'h06, 7'h07, 7'h35, 7'h45, 7'h05};
	logic [31:0] ps_cfg[3] = '{32'h0000_0020, 32'h0000_0022, 32'h0000_1020};
	logic [31:0] ps_exp[3] = '{32'h0000_0040, 32'h0000_0010, 32'h0000_0008};

	dual_timebase_ccu dut (
		.clk             (clk),
		.rst             (rst),
		.psel            (psel),
		.penable         (penable),
		.pwrite          (pwrite),
		.paddr           (paddr),
		.pwdata          (pwdata),
		.prdata          (prdata),
		.pready          (pready),
		.pslverr         (pslverr),
		.ch_in           (ch_in),
		.ch_out          (ch_out),
		.ch_oe           (ch_oe),
		.gp_timer_six_ovf(gp6),
		.ext_count_in    (ext),
		.irq             (irq)
	);
	channel_pin_model u_pins (.drv(drv), .ch_out(ch_out), .ch_oe(ch_oe), .ch_in(ch_in));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic logic [11:0] ca(input int c);
		return dual_timebase_ccu_pkg::ADDR_CH_CFG + 12'(4 * c);
	endfunction
	function automatic logic [11:0] va(input int c);
		return dual_timebase_ccu_pkg::ADDR_CH_VAL + 12'(4 * c);
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			fails++;
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		check(n, rd, e);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			gp6 <= 1'b1;
			@(posedge clk);
			gp6 <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask

	task automatic irq_step(input logic [11:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		repeat (2) @(posedge clk);
		check("irq", 32'(irq), 32'(e));
	endtask

	initial begin
		int i;
		int m;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		apb(1'b1, dual_timebase_ccu_pkg::ADDR_RLD_A, 32'h0000_fff0);
		rchk("reload_a", dual_timebase_ccu_pkg::ADDR_RLD_A, 32'h0000_fff0);
		rchk("unmapped", 12'h01c, 32'h0000_0000);
		check("unmapped_err", 32'(err), 32'h0000_0001);
		$display("test registers done");
		apb(1'b1, dual_timebase_ccu_pkg::ADDR_TB_CTRL, 32'h0000_0028);
		apb(1'b1, dual_timebase_ccu_pkg::ADDR_CNT_A, 32'h0000_fff0);
		for (i = 0; i < 6; i++) begin
			apb(1'b1, ca(ch_t[i]), {25'h0, cf_t[i]});
			apb(1'b1, va(ch_t[i]), (i == 5) ? 32'h0000_fff4 : 32'h0000_fff2);
		end
		ticks(2);
		rchk("status_1", dual_timebase_ccu_pkg::ADDR_INT_STATUS, 32'h0000_00bc);
		check("pins_1", 32'(ch_out & ch_oe), 32'h0000_00b0);
		check("oe_1", 32'(ch_oe), 32'h0000_00b0);
		apb(1'b1, dual_timebase_ccu_pkg::ADDR_INT_STATUS, 32'hffff_ffff);
		for (i = 0; i < 4; i++) apb(1'b1, va(ch_t[i]), 32'h0000_fff4);
		ticks(2);
		rchk("status_2", dual_timebase_ccu_pkg::ADDR_INT_STATUS, 32'h0000_8004);
		check("pins_2", 32'(ch_out & ch_oe), 32'h0000_0030);
		apb(1'b1, dual_timebase_ccu_pkg::ADDR_INT_STATUS, 32'hffff_ffff);
		ticks(12);
		rchk("status_ovf", dual_timebase_ccu_pkg::ADDR_INT_STATUS, 32'h0001_0000);
		check("pins_ovf", 32'(ch_out & ch_oe), 32'h0000_0020);
		rchk("count_a", dual_timebase_ccu_pkg::ADDR_CNT_A, 32'h0000_fff0);
		apb(1'b1, dual_timebase_ccu_pkg::ADDR_INT_STATUS, 32'hffff_ffff);
		ticks(4);
		rchk("status_3", dual_timebase_ccu_pkg::ADDR_INT_STATUS, 32'h0000_809c);
		check("pins_3", 32'(ch_out & ch_oe), 32'h0000_0030);
		$display("test compare done");
		apb(1'b1, dual_timebase_ccu_pkg::ADDR_TB_CTRL, 32'h0000_0000);
		apb(1'b1, dual_timebase_ccu_pkg::ADDR_INT_MASK, 32'h0000_0002);
		for (m = 1; m <= 3; m++) begin
			apb(1'b1, ca(1), 32'(m));
			apb(1'b1, dual_timebase_ccu_pkg::ADDR_CNT_A, 32'(m));
			drv[1] <= 1'b1;
			repeat (6) @(posedge clk);
			cap = (m != 2) ? 32'(m) : cap;
			rchk("cap_rise", va(1), cap);
			apb(1'b1, dual_timebase_ccu_pkg::ADDR_CNT_A, 32'(m + 16));
			drv[1] <= 1'b0;
			repeat (6) @(posedge clk);
			cap = (m != 1) ? 32'(m + 16) : cap;
			rchk("cap_fall", va(1), cap);
		end
		apb(1'b1, 12'h045, 32'h0000_0005);
		check("misaligned_err", 32'(err), 32'h0000_0001);
		rchk("misaligned_wr", ca(1), 32'h0000_0003);
		check("irq_cap", 32'(irq), 32'h0000_0001);
		rchk("status_cap", dual_timebase_ccu_pkg::ADDR_INT_STATUS, 32'h0000_809e);
		irq_step(dual_timebase_ccu_pkg::ADDR_INT_MASK, 32'h0000_0000, 1'b0);
		irq_step(dual_timebase_ccu_pkg::ADDR_INT_MASK, 32'h0000_0002, 1'b1);
		irq_step(dual_timebase_ccu_pkg::ADDR_INT_STATUS, 32'h0000_0002, 1'b0);
		$display("test capture done");
		apb(1'b1, dual_timebase_ccu_pkg::ADDR_TB_CTRL, 32'h0000_0c00);
		apb(1'b1, ca(6), 32'h0000_0009);
		repeat (3) begin
			@(posedge clk);
			ext <= 1'b1;
			repeat (4) @(posedge clk);
			ext <= 1'b0;
			repeat (4) @(posedge clk);
		end
		rchk("count_b", dual_timebase_ccu_pkg::ADDR_CNT_B, 32'h0000_0003);
		drv[6] <= 1'b1;
		repeat (6) @(posedge clk);
		rchk("cap_b", va(6), 32'h0000_0003);
		$display("test external count done");
		for (i = 0; i < 3; i++) begin
			apb(1'b1, dual_timebase_ccu_pkg::ADDR_CNT_A, 32'h0000_0000);
			apb(1'b1, dual_timebase_ccu_pkg::ADDR_TB_CTRL, ps_cfg[i]);
			// start and stop writes land 64 clocks apart
			repeat (61) @(posedge clk);
			apb(1'b1, dual_timebase_ccu_pkg::ADDR_TB_CTRL, 32'h0000_0000);
			rchk("prescale", dual_timebase_ccu_pkg::ADDR_CNT_A, ps_exp[i]);
		end
		$display("test prescaler done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
